// *** design/iocsd_defs.svh ***
// Address, field and code constants of the I/O chip-select decoder.
`ifndef IOCSD_DEFS_SVH
`define IOCSD_DEFS_SVH

`define IOCSD_MATCH_PORT   16'h3072
`define IOCSD_CFG_PORT     16'h2872
`define IOCSD_CFG_RESET    16'h0000
`define IOCSD_MATCH_RESET  16'h0000
`define IOCSD_UPPER_LSB    10
`define IOCSD_LOW_IGN_MAX  3'h4

`define IOCSD_CS_ROM       5'h00
`define IOCSD_CS_KBD       5'h01
`define IOCSD_CS_NPX       5'h02
`define IOCSD_CS_PWR0      5'h03
`define IOCSD_CS_RTC_ALE   5'h05
`define IOCSD_CS_RTC_WR    5'h06
`define IOCSD_CS_RTC_RD    5'h07
`define IOCSD_CS_FLP_OP    5'h08
`define IOCSD_CS_FLP       5'h09
`define IOCSD_CS_FLP_CTL   5'h0A
`define IOCSD_CS_SHR_CTL   5'h0B
`define IOCSD_CS_HD        5'h0C
`define IOCSD_CS_HD_CTL    5'h0D
`define IOCSD_CS_SER_A     5'h0E
`define IOCSD_CS_PAR       5'h0F
`define IOCSD_CS_SER_B     5'h10
`define IOCSD_CS_PROG      5'h11
`define IOCSD_CS_SCSI      5'h12
`define IOCSD_CS_FLUSH     5'h13
`define IOCSD_CS_EMS       5'h14
`define IOCSD_CS_EMS_SLOW  5'h15
`define IOCSD_CS_EMS_FAST  5'h16
`define IOCSD_CS_PWR1      5'h17
`define IOCSD_CS_FLP_DAT   5'h18
`define IOCSD_CS_FLP_DIR   5'h19
`define IOCSD_CS_IDLE      5'h1F

`define IOCSD_PORT_PWR0    16'h7072
`define IOCSD_PORT_PWR1    16'h7872
`define IOCSD_PORT_FLUSH   16'hF872
`define IOCSD_PORT_EMS     16'hF072
`define IOCSD_PORT_EMS2    16'hF472
`define IOCSD_SCSI_ROW     12'h353
`define IOCSD_NPX_ROW      11'h007
`define IOCSD_KBD_ROW      6'h06
`define IOCSD_RTC_ADDR     10'h070
`define IOCSD_RTC_DATA     10'h071
`define IOCSD_FLP_PRI      6'h3F
`define IOCSD_FLP_SEC      6'h37
`define IOCSD_HD_PRI       6'h1F
`define IOCSD_HD_SEC       6'h17
`define IOCSD_PAR_ROW0     7'h4F
`define IOCSD_PAR_ROW1     7'h6F
`define IOCSD_PAR_ROW2     8'hEF
`define IOCSD_SER_ROW1     7'h7F
`define IOCSD_SER_ROW2     7'h5F
`define IOCSD_SER_ROW3     7'h7D
`define IOCSD_SER_ROW4     7'h5D

`endif

// *** design/iocsd_pkg.sv ***
// Types shared by the I/O chip-select decoder modules.
package iocsd_pkg;

  typedef struct packed {
    logic       rtc_expansion;
    logic       fast_video;
    logic       fast_scsi;
    logic       prog_select_enable;
    logic       upper_addr_compare;
    logic [2:0] low_addr_ignore_field;
    logic       prog_expansion;
    logic       fast_hard_disk;
    logic       spare;
    logic       disk_secondary;
    logic       fast_coproc;
    logic       lock_password;
    logic       hard_disk_disable;
    logic       floppy_disable;
  } iocsd_cfg_t;

  typedef struct packed {
    logic        io_cycle;
    logic        rom_cycle;
    logic        write;
    logic        read;
    logic [15:0] addr;
    logic [15:0] wdata;
  } iocsd_cycle_t;

  typedef struct packed {
    logic       active;
    logic [4:0] code;
  } iocsd_sel_t;

  typedef struct packed {
    iocsd_cfg_t  cfg;
    logic [15:0] prog_select_match_address;
    iocsd_sel_t  sel;
    logic [15:0] rdata;
    logic        rdata_valid;
  } iocsd_state_t;

endpackage

// *** design/iocsd_fixed_decode.sv ***
// Combinational decode of the fixed peripheral port map.
`timescale 1ns/1ps
`include "iocsd_defs.svh"

module iocsd_fixed_decode
  import iocsd_pkg::*;
(
  input  wire logic [15:0] addr,
  input  wire logic        write,
  input  wire iocsd_cfg_t  cfg,
  input  wire logic [2:0]  serial_a_range,
  input  wire logic [2:0]  serial_b_range,
  input  wire logic        clk48_enable,
  output logic             hit,
  output logic [4:0]       code
);

  logic [9:0] a;
  logic [5:0] flp_row;
  logic [5:0] hd_row;
  logic       flp_on;
  logic       hd_on;

  // Serial ranges are eight ports wide; range values zero and five to seven mean disabled.
  function automatic logic serial_hit(input logic [2:0] range, input logic [9:0] low);
    logic [6:0] row;
    logic       en;
    row = 7'h00;
    en  = 1'b1;
    case (range)
      3'h1:    row = `IOCSD_SER_ROW1;
      3'h2:    row = `IOCSD_SER_ROW2;
      3'h3:    row = `IOCSD_SER_ROW3;
      3'h4:    row = `IOCSD_SER_ROW4;
      default: en = 1'b0;
    endcase
    return en && (low[9:3] == row);
  endfunction

  assign a       = addr[9:0];
  assign flp_row = cfg.disk_secondary ? `IOCSD_FLP_SEC : `IOCSD_FLP_PRI;
  assign hd_row  = cfg.disk_secondary ? `IOCSD_HD_SEC : `IOCSD_HD_PRI;
  assign flp_on  = !cfg.floppy_disable;
  assign hd_on   = !cfg.hard_disk_disable;

  // Checked in ascending code order, so serial A wins over serial B.
  always_comb begin
    hit  = 1'b1;
    code = `IOCSD_CS_IDLE;
    if (a[9:4] == `IOCSD_KBD_ROW && !a[0]) begin
      code = `IOCSD_CS_KBD;
    end else if (addr[15:5] == `IOCSD_NPX_ROW) begin
      code = `IOCSD_CS_NPX;
    end else if (addr == `IOCSD_PORT_PWR0) begin
      code = `IOCSD_CS_PWR0;
    end else if (a == `IOCSD_RTC_ADDR) begin
      code = `IOCSD_CS_RTC_ALE;
    end else if (a == `IOCSD_RTC_DATA) begin
      code = write ? `IOCSD_CS_RTC_WR : `IOCSD_CS_RTC_RD;
    end else if (flp_on && a == {flp_row, 4'h2}) begin
      code = `IOCSD_CS_FLP_OP;
    end else if (flp_on && a[9:1] == {flp_row, 3'h2}) begin
      code = `IOCSD_CS_FLP;
    end else if (flp_on && a == {flp_row, 4'h7}) begin
      code = hd_on ? `IOCSD_CS_SHR_CTL : `IOCSD_CS_FLP_CTL;
    end else if (hd_on && a[9:3] == {hd_row, 1'b0}) begin
      code = `IOCSD_CS_HD;
    end else if (hd_on && a[9:1] == {flp_row, 3'h3}) begin
      code = `IOCSD_CS_HD_CTL;
    end else if (serial_hit(serial_a_range, a)) begin
      code = `IOCSD_CS_SER_A;
    end else if (a[9:3] == `IOCSD_PAR_ROW0 || a[9:3] == `IOCSD_PAR_ROW1 || a[9:2] == `IOCSD_PAR_ROW2) begin
      code = `IOCSD_CS_PAR;
    end else if (serial_hit(serial_b_range, a)) begin
      code = `IOCSD_CS_SER_B;
    end else if (addr[15:4] == `IOCSD_SCSI_ROW) begin
      code = `IOCSD_CS_SCSI;
    end else if (addr == `IOCSD_PORT_FLUSH) begin
      code = `IOCSD_CS_FLUSH;
    end else if (addr == `IOCSD_PORT_EMS) begin
      code = `IOCSD_CS_EMS;
    end else if (addr == `IOCSD_PORT_EMS2) begin
      code = clk48_enable ? `IOCSD_CS_EMS_FAST : `IOCSD_CS_EMS_SLOW;
    end else if (addr == `IOCSD_PORT_PWR1) begin
      code = `IOCSD_CS_PWR1;
    end else if (flp_on && a[9:1] == {flp_row, 3'h0}) begin
      code = `IOCSD_CS_FLP_DAT;
    end else if (flp_on && a == {flp_row, 4'h3}) begin
      code = `IOCSD_CS_FLP_DIR;
    end else begin
      hit = 1'b0;
    end
  end

endmodule

// *** design/iocsd_top.sv ***
// I/O chip-select decoder with programmable select window and its registers.
//
// Summary of operation
// - Match register at port 3072H, 16 bits, readable and writable, bit n expects An.
// - Three-digit fixed ports compare only address lines A09 down to A00.
// - Selected peripheral is given as a five-bit code; 04, 1E, 1F are reserved.
// - Boot ROM cycles give code 00, independent of any port address.
// - Even ports 060 to 06E give keyboard controller code 01.
// - Ports 00E0 to 00FF give coprocessor code 02.
// - Port 3F7 or 377 gives 0A with floppy enabled and hard disk disabled.
// - With floppy and hard disk both enabled that port gives 0B.
// - 3F6/376 give 0D, plus 3F7/377 without floppy; 1F0-1F7/170-177 give 0C.
// - Ports 278-27F, 378-37F and 3BC-3BF give parallel code 0F.
// - Serial ports give 0E and 10; on equal ranges only the first is selected.
// - A programmable match that also hits a fixed decode is suppressed.
// - Port F072 gives 14; port F472 gives 15 with the fast clock disabled.
// - Port F472 gives 16 with the fast clock enabled.
// - Upper compare setting includes A15-A10 when one, ignores them when zero.
// - Low ignore field 0 to 4 drops A00 up to A03 from the compare.
// - Disk location bit picks primary or secondary floppy and hard disk rows.
`timescale 1ns/1ps
`include "iocsd_defs.svh"

module iocsd_top
  import iocsd_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  input  wire logic         clk_en,
  input  wire iocsd_cycle_t cyc,
  input  wire logic [2:0]   serial_a_range,
  input  wire logic [2:0]   serial_b_range,
  input  wire logic         clk48_enable,
  output iocsd_sel_t        sel,
  output logic [15:0]       rdata,
  output logic              rdata_valid
);

  localparam iocsd_state_t STATE_RESET = '{
    cfg:                       `IOCSD_CFG_RESET,
    prog_select_match_address: `IOCSD_MATCH_RESET,
    sel:                       '{active: 1'b0, code: `IOCSD_CS_IDLE},
    rdata:                     16'h0000,
    rdata_valid:               1'b0
  };

  iocsd_state_t st;
  iocsd_state_t next_st;
  logic         fixed_hit;
  logic [4:0]   fixed_code;
  logic [15:0]  care;
  logic [2:0]   ign_n;
  logic         prog_hit;

  ////////////////////////////////////////////////////////////////////////////////
  // Fixed port map.

  iocsd_fixed_decode u_fixed (
    .addr           (cyc.addr),
    .write          (cyc.write),
    .cfg            (st.cfg),
    .serial_a_range (serial_a_range),
    .serial_b_range (serial_b_range),
    .clk48_enable   (clk48_enable),
    .hit            (fixed_hit),
    .code           (fixed_code)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Programmable window compare.

  // Field values above four are clamped to the widest documented mask.
  assign ign_n = (st.cfg.low_addr_ignore_field > `IOCSD_LOW_IGN_MAX) ?
                 `IOCSD_LOW_IGN_MAX : st.cfg.low_addr_ignore_field;

  for (genvar i = 0; i < 16; i++) begin : g_care
    if (i >= `IOCSD_UPPER_LSB) begin : g_up
      assign care[i] = st.cfg.upper_addr_compare;
    end else begin : g_low
      assign care[i] = (int'(ign_n) <= i);
    end
  end

  assign prog_hit = st.cfg.prog_select_enable &&
                    (((cyc.addr ^ st.prog_select_match_address) & care) == 16'h0000);

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    next_st             = st;
    next_st.rdata_valid = 1'b0;
    if (cyc.rom_cycle) begin
      next_st.sel = '{active: 1'b1, code: `IOCSD_CS_ROM};
    end else if (cyc.io_cycle && fixed_hit) begin
      next_st.sel = '{active: 1'b1, code: fixed_code};
    end else if (cyc.io_cycle && prog_hit) begin
      next_st.sel = '{active: 1'b1, code: `IOCSD_CS_PROG};
    end else begin
      next_st.sel = '{active: 1'b0, code: `IOCSD_CS_IDLE};
    end
    if (cyc.io_cycle && cyc.write) begin
      if (cyc.addr == `IOCSD_MATCH_PORT) begin
        next_st.prog_select_match_address = cyc.wdata;
      end else if (cyc.addr == `IOCSD_CFG_PORT) begin
        next_st.cfg = cyc.wdata;
      end
    end
    if (cyc.io_cycle && cyc.read) begin
      if (cyc.addr == `IOCSD_MATCH_PORT) begin
        next_st.rdata       = st.prog_select_match_address;
        next_st.rdata_valid = 1'b1;
      end else if (cyc.addr == `IOCSD_CFG_PORT) begin
        next_st.rdata       = st.cfg;
        next_st.rdata_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= STATE_RESET;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign sel         = st.sel;
  assign rdata       = st.rdata;
  assign rdata_valid = st.rdata_valid;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  logic io_only;
  assign io_only = clk_en && cyc.io_cycle && !cyc.rom_cycle;

  rom_code_a: assert property (clk_en && cyc.rom_cycle |=> sel.active && sel.code == `IOCSD_CS_ROM)
    else $error("ROM cycle did not give the ROM code");
  kbd_code_a: assert property (io_only && cyc.addr[9:4] == 6'h06 && !cyc.addr[0] |=> sel.code == `IOCSD_CS_KBD)
    else $error("Keyboard port not decoded");
  npx_code_a: assert property (io_only && cyc.addr[15:5] == 11'h007 |=> sel.active && sel.code == `IOCSD_CS_NPX)
    else $error("Coprocessor port not decoded");
  flp_ctl_a: assert property (io_only && cyc.addr[9:0] == 10'h3F7 && !st.cfg.disk_secondary && !st.cfg.floppy_disable
                              |=> sel.code == ($past(st.cfg.hard_disk_disable) ? 5'h0A : 5'h0B))
    else $error("Shared control port code wrong");
  hd_ctl_a: assert property (io_only && cyc.addr[9:0] == 10'h376 && st.cfg.disk_secondary && !st.cfg.hard_disk_disable
                             |=> sel.code == `IOCSD_CS_HD_CTL)
    else $error("Secondary disk control port not decoded");
  par_code_a: assert property (io_only && cyc.addr[9:2] == 8'hEF |=> sel.code == `IOCSD_CS_PAR)
    else $error("Parallel port not decoded");
  ser_prio_a: assert property (io_only && serial_a_range == 3'h1 && serial_b_range == 3'h1 && cyc.addr[9:3] == 7'h7F
                               |=> sel.code == `IOCSD_CS_SER_A)
    else $error("Second serial select not suppressed");
  ems_code_a: assert property (io_only && cyc.addr == 16'hF472 |=> sel.code == ($past(clk48_enable) ? 5'h16 : 5'h15))
    else $error("Expanded memory port code wrong");
  prog_sup_a: assert property (io_only && fixed_hit |=> sel.code != `IOCSD_CS_PROG)
    else $error("Programmable select not suppressed");
  prog_sel_a: assert property (io_only && !fixed_hit |=> (sel.code == `IOCSD_CS_PROG) == $past(prog_hit))
    else $error("Programmable select decision wrong");
  prog_off_a: assert property (sel.code == `IOCSD_CS_PROG |-> st.cfg.prog_select_enable || $past(st.cfg.prog_select_enable))
    else $error("Programmable select while disabled");
  match_reg_a: assert property (io_only && cyc.write && cyc.addr == `IOCSD_MATCH_PORT ##1
                                io_only && cyc.read && !cyc.write && cyc.addr == `IOCSD_MATCH_PORT
                                |=> rdata_valid && rdata == $past(cyc.wdata, 2))
    else $error("Match register readback wrong");
  idle_sel_a: assert property (clk_en && !cyc.io_cycle && !cyc.rom_cycle |=> !sel.active && sel.code == `IOCSD_CS_IDLE)
    else $error("Select driven outside a cycle");

  // A low clock enable must leave every registered output exactly where it was.
  freeze_hold_a: assert property (!clk_en |=> $stable(sel) && $stable(rdata) && $stable(rdata_valid))
    else $error("Outputs moved while the clock enable was low");
  rtc_strobe_a: assert property (io_only && cyc.addr[9:0] == 10'h071
                                 |=> sel.code == ($past(cyc.write) ? 5'h06 : 5'h07))
    else $error("Clock chip strobe code wrong");
  scsi_code_a: assert property (io_only && cyc.addr[15:4] == 12'h353 |=> sel.code == `IOCSD_CS_SCSI)
    else $error("SCSI port not decoded");
  ems_ext_a: assert property (io_only && cyc.addr == 16'hF072 |=> sel.code == `IOCSD_CS_EMS)
    else $error("External expanded memory port not decoded");
  hd_data_a: assert property (io_only && cyc.addr[9:3] == 7'h3E && !st.cfg.disk_secondary && !st.cfg.hard_disk_disable
                              |=> sel.code == `IOCSD_CS_HD)
    else $error("Primary hard disk data port not decoded");
  hd_off_a: assert property (io_only && cyc.addr[9:3] == 7'h3E && st.cfg.hard_disk_disable
                             |=> sel.code != `IOCSD_CS_HD)
    else $error("Hard disk decoded while disabled");
  flp_off_a: assert property (io_only && cyc.addr[9:0] == 10'h3F2 && st.cfg.floppy_disable
                              |=> sel.code != `IOCSD_CS_FLP_OP)
    else $error("Floppy decoded while disabled");
  reg_read_a: assert property (io_only && cyc.read && !cyc.write && cyc.addr == `IOCSD_CFG_PORT
                               |=> rdata_valid && rdata == $past(st.cfg))
    else $error("Configuration readback wrong");

  fixed_hit_c: cover property (io_only && fixed_hit ##1 sel.active);
  prog_hit_c: cover property (io_only && !fixed_hit && prog_hit ##1 sel.code == `IOCSD_CS_PROG);
  shared_ctl_c: cover property (clk_en ##1 sel.code == `IOCSD_CS_SHR_CTL);
  reg_read_c: cover property (rdata_valid);
  freeze_c: cover property (sel.active && !clk_en ##1 sel.active);

endmodule

// *** dv/iocsd_host_model.sv ***
// Host processor model that issues one I/O or boot ROM cycle at a time.
`timescale 1ns/1ps

module iocsd_host_model
  import iocsd_pkg::*;
(
  input  wire logic    ref_clk,
  output iocsd_cycle_t cyc
);
  initial cyc = '0;

  // After the taking edge the strobes drop to zero and the address and data lines go to the inverse of the last value.
  task automatic go(input logic io, rom, wr, rd, input logic [15:0] a, d);
    @(posedge ref_clk);
    #1;
    cyc = '{io, rom, wr, rd, a, d};
    @(posedge ref_clk);
    #1;
    cyc = '{1'b0, 1'b0, 1'b0, 1'b0, ~a, ~d};
  endtask
endmodule

// *** dv/io_chip_select_decoder_test.sv ***
// Self-checking testbench of the I/O chip-select decoder.
`timescale 1ns/1ps

module io_chip_select_decoder_test;
  import iocsd_pkg::*;
  logic         ref_clk = 1'b0;
  logic         rst_b = 1'b0;
  logic [2:0]   ser_a = 3'h1;
  logic [2:0]   ser_b = 3'h2;
  logic         clk48 = 1'b0;
  logic         clk_en = 1'b1;
  iocsd_cycle_t cyc;
  iocsd_sel_t   sel;
  logic [15:0]  rdata;
  logic         rdata_valid;
  int           bad_count = 0;
  int           total_checks = 0;

  always #5 ref_clk = ~ref_clk;

  iocsd_host_model host_u (.ref_clk(ref_clk), .cyc(cyc));

  iocsd_top dut_u (
    .ref_clk       (ref_clk),
    .rst_b         (rst_b),
    .clk_en        (clk_en),
    .cyc           (cyc),
    .serial_a_range(ser_a),
    .serial_b_range(ser_b),
    .clk48_enable  (clk48),
    .sel           (sel),
    .rdata         (rdata),
    .rdata_valid   (rdata_valid)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_code(input logic [15:0] a, input logic [4:0] e);
    total_checks++;
    if (!(sel.code === e && sel.active === (e !== 5'h1f))) begin
      bad_count++;
      $display("unexpected code at %h expected %h seen %h", a, e, sel.code);
    end
  endtask

  task automatic chk_word(input logic [15:0] a, e);
    total_checks++;
    if (!(rdata === e && rdata_valid === 1'b1)) begin
      bad_count++;
      $display("unexpected rdata at %h expected %h seen %h", a, e, rdata);
    end
  endtask

  task automatic io(input logic [15:0] a, input logic [4:0] e);
    host_u.go(1'b1, 1'b0, 1'b0, 1'b0, a, 16'h0000);
    chk_code(a, e);
  endtask

  task automatic wr(input logic [15:0] a, d);
    host_u.go(1'b1, 1'b0, 1'b1, 1'b0, a, d);
  endtask

  task automatic rd(input logic [15:0] a, e);
    host_u.go(1'b1, 1'b0, 1'b0, 1'b1, a, 16'h0000);
    chk_word(a, e);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk_code(16'h0000, 5'h1f);
    rd(16'h3072, 16'h0000);
    rd(16'h2872, 16'h0000);
    $display("done t_reset");
  endtask

  task automatic t_fixed();
    logic [15:0] fa [26] = '{16'h0060, 16'h006E, 16'h0061, 16'h00E0, 16'h00FF, 16'h00DF, 16'h7072,
      16'h0070, 16'h03F2, 16'h03F4, 16'h03F7, 16'h01F7, 16'h03F6, 16'h0278, 16'h037F, 16'h03BC,
      16'h3530, 16'hF872, 16'hF072, 16'hF472, 16'h7872, 16'h03F1, 16'h03F3, 16'hFC64, 16'h03F8, 16'h02F8};
    logic [4:0] fc [26] = '{5'h01, 5'h01, 5'h1f, 5'h02, 5'h02, 5'h1f, 5'h03, 5'h05, 5'h08, 5'h09,
      5'h0b, 5'h0c, 5'h0d, 5'h0f, 5'h0f, 5'h0f, 5'h12, 5'h13, 5'h14, 5'h15, 5'h17, 5'h18, 5'h19,
      5'h01, 5'h0e, 5'h10};
    for (int i = 0; i < 26; i++) begin
      io(fa[i], fc[i]);
    end
    host_u.go(1'b1, 1'b0, 1'b1, 1'b0, 16'h0071, 16'h0000);
    chk_code(16'h0071, 5'h06);
    host_u.go(1'b1, 1'b0, 1'b0, 1'b1, 16'h0071, 16'h0000);
    chk_code(16'h0071, 5'h07);
    host_u.go(1'b0, 1'b1, 1'b0, 1'b1, 16'h0060, 16'h0000);
    chk_code(16'h0060, 5'h00);
    clk48 = 1'b1;
    io(16'hF472, 5'h16);
    ser_b = 3'h1;
    io(16'h03F8, 5'h0e);
    $display("done t_fixed");
  endtask

  task automatic t_disk();
    wr(16'h2872, 16'h0001);
    io(16'h03F7, 5'h0d);
    wr(16'h2872, 16'h0002);
    io(16'h03F7, 5'h0a);
    io(16'h01F0, 5'h1f);
    wr(16'h2872, 16'h0010);
    io(16'h0377, 5'h0b);
    io(16'h0170, 5'h0c);
    io(16'h0372, 5'h08);
    $display("done t_disk");
  endtask

  task automatic t_prog();
    wr(16'h3072, 16'h0123);
    rd(16'h3072, 16'h0123);
    wr(16'h2872, 16'h0000);
    io(16'h0123, 5'h1f);
    wr(16'h2872, 16'h1000);
    rd(16'h2872, 16'h1000);
    io(16'h0123, 5'h11);
    io(16'hFD23, 5'h11);
    io(16'h0122, 5'h1f);
    wr(16'h2872, 16'h1800);
    io(16'hFD23, 5'h1f);
    io(16'h0123, 5'h11);
    wr(16'h2872, 16'h1400);
    io(16'h012E, 5'h11);
    io(16'h0133, 5'h1f);
    wr(16'h2872, 16'h1100);
    io(16'h0122, 5'h11);
    wr(16'h3072, 16'h0060);
    io(16'h0060, 5'h01);
    $display("done t_prog");
  endtask

  // A cycle presented while the enable is low must not reach the outputs.
  task automatic t_freeze();
    io(16'h0060, 5'h01);
    clk_en = 1'b0;
    host_u.go(1'b1, 1'b0, 1'b0, 1'b0, 16'h00E0, 16'h0000);
    chk_code(16'h00E0, 5'h01);
    clk_en = 1'b1;
    io(16'h00E0, 5'h02);
    $display("done t_freeze");
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    t_reset();
    t_fixed();
    t_disk();
    t_prog();
    t_freeze();
    give_verdict();
  end

  initial begin
    #100000;
    bad_count++;
    give_verdict();
  end
endmodule
